// ---- hdl/tag_map.svh ----
// constants of the egress status tag inserter: offsets, resets, counts
`ifndef TAG_MAP_SVH
`define TAG_MAP_SVH

`define TAG_ETHERTYPE_RST 16'h88C3
`define TAG_BYTE_COUNT 8
`define TAG_FIFO_DEPTH 8
`define TAG_HEAD_LAST 4'hB
`define TAG_TAG_LAST 4'h7
`define TAG_FCS_LAST 4'h3
`define TAG_LEN_ADD 14'h0008
`define TAG_OFS_ADD 6'h08
`define TAG_CRC_INIT 32'hFFFFFFFF
`define TAG_CRC_POLY 32'hEDB88320
`define TAG_B0_ERR_BIT 3
`define TAG_B0_DROP_BIT 2
`define TAG_RSVD_BYTE 8'h00

`endif

// ---- hdl/tag_pkg.sv ----
// types shared by the egress status tag inserter files
package tag_pkg;
    typedef logic [7:0] byte_t;
    typedef enum {ST_IDLE, ST_HEAD, ST_TAG, ST_BODY, ST_FCS} ins_state_t;
endpackage : tag_pkg

// ---- hdl/tag_fifo_if.sv ----
// fifo carrier between the inserter core and its byte buffer
`timescale 1ns/10ps
interface tag_fifo_if #(parameter int WIDTH = 9);
    logic wr_valid; // producer offers a word
    logic wr_ready; // buffer has room
    logic [WIDTH-1:0] wr_data; // word written
    logic afull; // at most one slot left
    logic rd_valid; // buffer holds a word
    logic rd_ready; // consumer takes the word
    logic [WIDTH-1:0] rd_data; // head word
    modport sink (input wr_valid, wr_data, rd_ready, output wr_ready, afull, rd_valid, rd_data);
    modport user (output wr_valid, wr_data, rd_ready, input wr_ready, afull, rd_valid, rd_data);
endinterface : tag_fifo_if

// ---- hdl/tag_fifo.sv ----
// byte buffer between tag insertion and the output stage
`timescale 1ns/10ps
module tag_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk_in, // core clock
    input wire logic reset_n_in, // async reset, active low
    tag_fifo_if.sink port // write and read sides
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH]; // storage words
    logic [AW-1:0] wptr_reg; // write slot
    logic [AW-1:0] rptr_reg; // read slot
    logic [AW:0] count_reg; // words held
    wire do_wr = port.wr_valid && port.wr_ready; // write taken
    wire do_rd = port.rd_valid && port.rd_ready; // read taken
    assign port.wr_ready = (count_reg != (AW+1)'(DEPTH));
    assign port.afull = (count_reg >= (AW+1)'(DEPTH - 1));
    assign port.rd_valid = (count_reg != '0);
    assign port.rd_data = mem[rptr_reg];
    ////////////////////////////////////////////////////////////////////
    // storage has no reset: only count decides what is valid
    always_ff @(posedge clk_in) begin
        if (do_wr) begin
            mem[wptr_reg] <= port.wr_data;
        end
    end
    // pointers wrap at depth, which need not be a power of two
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (do_wr) begin
                wptr_reg <= (wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + 1'b1;
            end
            if (do_rd) begin
                rptr_reg <= (rptr_reg == AW'(DEPTH - 1)) ? '0 : rptr_reg + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count_reg <= count_reg + 1'b1;
            end else if (do_rd && !do_wr) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule : tag_fifo

// ---- hdl/egress_status_tag_inserter.sv ----
// egress status tag inserter: adds the per-frame status tag after the source mac
`timescale 1ns/10ps
`include "tag_map.svh"
module egress_status_tag_inserter #(
    parameter int NPORTS = 7,
    parameter int FIFO_DEPTH = `TAG_FIFO_DEPTH
) (
    input wire logic clk_in, // core clock, 100 MHz
    input wire logic reset_n_in, // async reset, active low
    input wire logic [NPORTS-1:0] tag_enable_in, // per port tag on
    input wire logic [NPORTS-1:0] tag_internal_in, // per port internal format
    input wire logic ethertype_load_in, // load new ethertype
    input wire logic [15:0] ethertype_value_in, // ethertype to load
    input wire tag_pkg::byte_t in_data_in, // frame byte, no fcs
    input wire logic in_valid_in, // byte offered
    input wire logic in_last_in, // last byte of frame
    output logic in_ready_out, // byte may be offered
    input wire logic [2:0] meta_egress_port_in, // egress port of frame
    input wire logic meta_pause_in, // mac pause frame
    input wire logic [3:0] meta_tc_in, // traffic class
    input wire logic [3:0] meta_ingress_port_in, // ingress port index
    input wire logic meta_pppoe_in, // pppoe session
    input wire logic meta_ipv4_in, // ipv4 when set
    input wire logic [5:0] meta_l3_header_position_in, // ip start, untagged
    input wire logic [7:0] meta_port_map_in, // destination port map
    input wire logic meta_duplicated_copy_in, // mirrored copy
    input wire logic meta_l2_known_in, // bridging table hit
    input wire logic [13:0] meta_length_in, // length with fcs, untagged
    input wire logic meta_mac_error_in, // mac receive error
    input wire logic meta_dropped_in, // dropped, mirror only
    input wire logic [1:0] meta_precedence_in, // drop precedence
    input wire logic [7:0] meta_flow_id_in, // flow identification
    input wire logic [7:0] meta_error_code_in, // error code
    output tag_pkg::byte_t out_data_out, // egress byte
    output logic out_valid_out, // egress byte valid
    output logic out_last_out, // last fcs byte
    input wire logic out_ready_in, // egress sink ready
    output logic busy_out // frame in progress
);
    import tag_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // declarations
    ins_state_t state_reg, state_next; // insertion sequencer
    logic [3:0] cnt_reg, cnt_next; // byte counter within a phase
    logic [31:0] crc_reg, crc_next; // running fcs
    logic [15:0] eth_reg; // configured ethertype
    logic in_ready_reg; // registered input ready
    logic tag_on_reg; // this frame carries a tag
    logic internal_reg; // this frame uses internal format
    logic [3:0] tc_reg; // captured traffic class
    logic [3:0] inport_reg; // captured ingress port
    logic pppoe_reg; // captured pppoe flag
    logic ipv4_reg; // captured ip version
    logic [5:0] l3pos_reg; // captured ip position
    logic [7:0] pmap_reg; // captured port map
    logic dup_reg; // captured mirror flag
    logic known_reg; // captured table hit
    logic [13:0] len_reg; // captured length
    logic err_reg; // captured mac error
    logic drop_reg; // captured drop flag
    logic [1:0] prec_reg; // captured precedence
    logic [7:0] flow_reg; // captured flow id
    logic [7:0] ecode_reg; // captured error code
    byte_t out_data_reg; // output stage data
    logic out_valid_reg; // output stage valid
    logic out_last_reg; // output stage last
    logic busy_reg; // frame in progress
    tag_fifo_if #(.WIDTH(9)) fifo (); // buffer carrier

    ////////////////////////////////////////////////////////////////////
    // fcs over one byte, reflected ethernet polynomial
    function automatic logic [31:0] crc_step(input logic [31:0] c, input byte_t d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `TAG_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_step

    ////////////////////////////////////////////////////////////////////
    // decode of handshakes and tag content
    wire accept = in_valid_in && in_ready_reg; // input byte taken
    wire gen_phase = (state_reg == ST_TAG) || (state_reg == ST_FCS); // block makes bytes
    wire gen_write = gen_phase && fifo.wr_ready; // generated byte stored
    wire [2:0] eport = meta_egress_port_in; // egress port at frame start
    wire port_ok = (32'(eport) < NPORTS); // out of range port never tagged
    wire want_tag = port_ok && tag_enable_in[eport] && !meta_pause_in;
    wire want_int = port_ok && tag_internal_in[eport]; // format chosen per port
    wire [13:0] len_adj = len_reg + `TAG_LEN_ADD;
    wire [5:0] l3_adj = (l3pos_reg == 6'h00) ? 6'h00 : l3pos_reg + `TAG_OFS_ADD;
    wire [7:0] b0_int = {4'h0, err_reg, drop_reg, prec_reg};
    wire [7:0] b1_int = (err_reg || drop_reg) ? ecode_reg : flow_reg;
    wire [7:0] b0 = internal_reg ? b0_int : eth_reg[15:8];
    wire [7:0] b1 = internal_reg ? b1_int : eth_reg[7:0];
    wire [7:0] b2 = {tc_reg, inport_reg};
    wire [7:0] b3 = {pppoe_reg, ipv4_reg, l3_adj};
    wire [7:0] b4 = pmap_reg;
    wire [7:0] b5 = `TAG_RSVD_BYTE;
    wire [7:0] b6 = {dup_reg, known_reg, len_adj[13:8]};
    wire [7:0] b7 = len_adj[7:0];
    wire [31:0] crc_inv = ~crc_reg; // fcs is the inverted remainder
    wire [7:0] fcs_byte = crc_inv[{cnt_reg[1:0], 3'b000} +: 8]; // low byte first
    wire [7:0] tag_byte = (cnt_reg[2:0] == 3'h0) ? b0 :
                          (cnt_reg[2:0] == 3'h1) ? b1 :
                          (cnt_reg[2:0] == 3'h2) ? b2 :
                          (cnt_reg[2:0] == 3'h3) ? b3 :
                          (cnt_reg[2:0] == 3'h4) ? b4 :
                          (cnt_reg[2:0] == 3'h5) ? b5 :
                          (cnt_reg[2:0] == 3'h6) ? b6 : b7;
    wire [7:0] wr_byte = (state_reg == ST_TAG) ? tag_byte :
                         (state_reg == ST_FCS) ? fcs_byte : in_data_in;
    wire wr_last = (state_reg == ST_FCS) && (cnt_reg == `TAG_FCS_LAST); // frame end
    wire pass_next = (state_next == ST_IDLE) || (state_next == ST_HEAD) ||
                     (state_next == ST_BODY); // input may flow next cycle
    wire out_load = fifo.rd_valid && (!out_valid_reg || out_ready_in); // refill output
    assign fifo.wr_valid = accept || gen_write;
    assign fifo.wr_data = {wr_last, wr_byte};
    assign fifo.rd_ready = out_load;

    ////////////////////////////////////////////////////////////////////
    // byte buffer ahead of the output stage
    tag_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .port(fifo)
    );

    ////////////////////////////////////////////////////////////////////
    // sequencer: head, tag, body, fcs
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            ST_IDLE: begin
                // first byte of a frame starts the header count
                if (accept) begin
                    state_next = in_last_in ? ST_FCS : ST_HEAD;
                    cnt_next = in_last_in ? 4'h0 : 4'h1;
                end
            end
            ST_HEAD: begin
                // tag only after both mac addresses have gone by
                if (accept) begin
                    cnt_next = cnt_reg + 4'h1;
                    if (in_last_in) begin
                        state_next = ST_FCS;
                        cnt_next = 4'h0;
                    end else if (cnt_reg == `TAG_HEAD_LAST) begin
                        state_next = tag_on_reg ? ST_TAG : ST_BODY;
                        cnt_next = 4'h0;
                    end
                end
            end
            ST_TAG: begin
                // eight generated bytes, input held off meanwhile
                if (gen_write) begin
                    cnt_next = cnt_reg + 4'h1;
                    if (cnt_reg == `TAG_TAG_LAST) begin
                        state_next = ST_BODY;
                        cnt_next = 4'h0;
                    end
                end
            end
            ST_BODY: begin
                // pass payload until the source marks its end
                if (accept && in_last_in) begin
                    state_next = ST_FCS;
                    cnt_next = 4'h0;
                end
            end
            ST_FCS: begin
                // four fcs bytes over the tagged frame
                if (gen_write) begin
                    cnt_next = cnt_reg + 4'h1;
                    if (cnt_reg == `TAG_FCS_LAST) begin
                        state_next = ST_IDLE;
                        cnt_next = 4'h0;
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
                cnt_next = 4'h0;
            end
        endcase
    end

    // fcs restarts with the first byte of every frame
    always_comb begin
        crc_next = crc_reg;
        if (accept && (state_reg == ST_IDLE)) begin
            crc_next = crc_step(`TAG_CRC_INIT, in_data_in);
        end else if (accept || (gen_write && (state_reg == ST_TAG))) begin
            crc_next = crc_step(crc_reg, wr_byte);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer registers; ready is registered and keeps one slot spare
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            crc_reg <= `TAG_CRC_INIT;
            in_ready_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            crc_reg <= crc_next;
            in_ready_reg <= pass_next && !fifo.afull;
            busy_reg <= (state_next != ST_IDLE);
        end
    end

    // ethertype defaults to the documented value until software loads one
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            eth_reg <= `TAG_ETHERTYPE_RST;
        end else if (ethertype_load_in) begin
            eth_reg <= ethertype_value_in;
        end
    end

    // frame status is captured once, with the first byte
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tag_on_reg <= 1'b0;
            internal_reg <= 1'b0;
            {tc_reg, inport_reg, pppoe_reg, ipv4_reg, l3pos_reg} <= '0;
            {pmap_reg, dup_reg, known_reg, len_reg} <= '0;
            {err_reg, drop_reg, prec_reg, flow_reg, ecode_reg} <= '0;
        end else if (accept && (state_reg == ST_IDLE)) begin
            tag_on_reg <= want_tag;
            internal_reg <= want_int;
            {tc_reg, inport_reg} <= {meta_tc_in, meta_ingress_port_in};
            {pppoe_reg, ipv4_reg} <= {meta_pppoe_in, meta_ipv4_in};
            l3pos_reg <= meta_l3_header_position_in;
            {pmap_reg, dup_reg, known_reg} <= {meta_port_map_in, meta_duplicated_copy_in,
                                               meta_l2_known_in};
            len_reg <= meta_length_in;
            {err_reg, drop_reg, prec_reg} <= {meta_mac_error_in, meta_dropped_in,
                                              meta_precedence_in};
            {flow_reg, ecode_reg} <= {meta_flow_id_in, meta_error_code_in};
        end
    end

    // output stage: every egress pin comes from a flop
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            out_valid_reg <= 1'b0;
            out_data_reg <= 8'h00;
            out_last_reg <= 1'b0;
        end else if (out_load) begin
            out_valid_reg <= 1'b1;
            {out_last_reg, out_data_reg} <= fifo.rd_data;
        end else if (out_ready_in) begin
            out_valid_reg <= 1'b0;
        end
    end

    assign in_ready_out = in_ready_reg;
    assign out_data_out = out_data_reg;
    assign out_valid_out = out_valid_reg;
    assign out_last_out = out_last_reg;
    assign busy_out = busy_reg;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    wire tag_wr = gen_write && (state_reg == ST_TAG); // tag byte stored

    a_tag_only_enabled: assert property ((state_reg == ST_TAG) |-> tag_on_reg)
        else $error("tag sent on a frame without tag");
    a_pause_no_tag: assert property ((accept && state_reg == ST_IDLE && meta_pause_in)
        |=> !tag_on_reg)
        else $error("pause frame marked for tag");
    // each ethertype byte checked in its own slot: a stalled write repeats the same byte
    a_ext_ethertype: assert property ((tag_wr && !internal_reg && cnt_reg[3:1] == 3'h0)
        |-> wr_byte == (cnt_reg[0] ? eth_reg[7:0] : eth_reg[15:8]))
        else $error("ethertype bytes wrong");
    a_int_nibble_zero: assert property ((tag_wr && internal_reg && cnt_reg == 4'h0)
        |-> wr_byte[7:4] == 4'h0)
        else $error("internal byte zero nibble not zero");
    a_tag_eight_bytes: assert property ((tag_wr && cnt_reg == `TAG_TAG_LAST)
        |=> state_reg == ST_BODY)
        else $error("tag length not eight");
    a_head_twelve: assert property ((state_reg == ST_HEAD && accept && !in_last_in &&
        cnt_reg == `TAG_HEAD_LAST && tag_on_reg) |=> state_reg == ST_TAG && cnt_reg == 4'h0)
        else $error("tag not after source mac");
    a_len_includes: assert property ((tag_wr && cnt_reg == 4'h7)
        |-> wr_byte == 8'(len_reg + 14'h0008))
        else $error("length low byte wrong");
    a_flow_select: assert property ((tag_wr && internal_reg && cnt_reg == 4'h1 &&
        !err_reg && !drop_reg) |-> wr_byte == flow_reg)
        else $error("flow id not sent on good frame");
    a_fcs_four: assert property ((state_reg == ST_BODY && accept && in_last_in)
        |=> (state_reg == ST_FCS) [*4] ##1 1'b1)
        else $error("fcs phase shorter than four");
    a_fifo_no_overrun: assert property (accept |-> fifo.wr_ready)
        else $error("input byte with buffer full");
    // content bytes, every field checked; one check covers several fields in bytes 0, 2 and 6
    a_class_port: assert property ((tag_wr && cnt_reg == 4'h2)
        |-> wr_byte == {tc_reg, inport_reg})
        else $error("class or ingress port byte wrong");
    a_pppoe_flag: assert property ((tag_wr && cnt_reg == 4'h3)
        |-> wr_byte[7] == pppoe_reg)
        else $error("pppoe flag wrong");
    a_ip_version: assert property ((tag_wr && cnt_reg == 4'h3)
        |-> wr_byte[6] == ipv4_reg)
        else $error("ip version flag wrong");
    a_l3_position: assert property ((tag_wr && cnt_reg == 4'h3 && l3pos_reg != 6'h00)
        |-> 6'(wr_byte[5:0] - l3pos_reg) == `TAG_OFS_ADD)
        else $error("ip position not shifted by tag");
    a_port_map: assert property ((tag_wr && cnt_reg == 4'h4)
        |-> wr_byte == pmap_reg)
        else $error("port map byte wrong");
    a_reserved_zero: assert property ((tag_wr && cnt_reg == 4'h5)
        |-> wr_byte == `TAG_RSVD_BYTE)
        else $error("reserved byte not zero");
    a_mirror_known: assert property ((tag_wr && cnt_reg == 4'h6)
        |-> wr_byte[7:6] == {dup_reg, known_reg})
        else $error("mirror or table flag wrong");
    a_len_high: assert property ((tag_wr && cnt_reg == 4'h6)
        |-> wr_byte[5:0] == 6'((len_reg + `TAG_LEN_ADD) >> 8))
        else $error("length high bits wrong");
    a_int_status: assert property ((tag_wr && internal_reg && cnt_reg == 4'h0)
        |-> wr_byte[`TAG_B0_ERR_BIT] == err_reg && wr_byte[`TAG_B0_DROP_BIT] == drop_reg &&
        wr_byte[1:0] == prec_reg)
        else $error("internal status bits wrong");
    a_error_code: assert property ((tag_wr && internal_reg && cnt_reg == 4'h1 &&
        (err_reg || drop_reg)) |-> wr_byte == ecode_reg)
        else $error("error code not sent on bad frame");

    c_external_tag: cover property (tag_wr && !internal_reg && cnt_reg == 4'h7);
    c_internal_tag: cover property (tag_wr && internal_reg && cnt_reg == 4'h7);
    c_pause_frame: cover property (accept && state_reg == ST_IDLE && meta_pause_in);
    c_buffer_full: cover property (!fifo.wr_ready);
endmodule : egress_status_tag_inserter

// ---- verif/egress_sink_model.sv ----
// receiving host model: takes egress bytes and counts the frames closed by last
`timescale 1ns/10ps
module egress_sink_model (
    input wire logic clk_in, // core clock
    input wire logic reset_n_in, // async reset, active low
    input wire logic [7:0] data_in, // egress byte
    input wire logic valid_in, // byte valid
    input wire logic last_in, // frame end
    input wire logic stall_in, // hold ready low
    input wire logic slow_in, // ready every other cycle
    output logic ready_out // byte accepted
);
    logic [7:0] got[$]; // bytes of the open frame, parsed by the bench
    int frames; // frames closed by last
    ////////////////////////////////////////////////////////////////////////
    // accept bytes; stall and slow model a host that falls behind
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ready_out <= 1'b0;
            frames <= 0;
        end else begin
            ready_out <= !stall_in && (!slow_in || !ready_out);
            if (valid_in && ready_out) begin
                got.push_back(data_in);
                if (last_in) frames <= frames + 1; // frame boundary
            end
        end
    end
endmodule : egress_sink_model

// ---- verif/tb_egress_status_tag_inserter.sv ----
// self-checking bench of the egress status tag inserter
`timescale 1ns/10ps
`include "tag_map.svh"
module tb_egress_status_tag_inserter;
    logic clk_in = 1'b0; // core clock
    logic rst_n = 1'b0; // reset, active low
    logic [6:0] en = 7'h7F; // per port tag on
    logic [6:0] intl = 7'h00; // per port internal format
    logic eld = 1'b0, ppp = 1'b0, v4 = 1'b0, dup = 1'b0, kn = 1'b0, err = 1'b0, drp = 1'b0;
    logic v = 1'b0, l = 1'b0, pau = 1'b0, stall = 1'b0, slow = 1'b0, ov, ol, ordy, rdy, busy;
    logic [15:0] ev = 16'h0000, etype = 16'h88C3; // load value and bench copy
    logic [7:0] d = 8'h00, pmap = 8'h00, flow = 8'h00, ecode = 8'h00, od;
    logic [2:0] eport = 3'h3; // egress port under test
    logic [3:0] tc = 4'h0, ipt = 4'h0; // class and ingress port
    logic [5:0] l3 = 6'h00; // untagged ip start
    logic [13:0] len = 14'h0000; // untagged length
    logic [1:0] prec = 2'h0; // drop precedence
    int n_errors = 0;
    int num_checks = 0;
    always #5 clk_in = ~clk_in; // 100 MHz
    egress_status_tag_inserter dut (.clk_in(clk_in), .reset_n_in(rst_n), .tag_enable_in(en),
        .tag_internal_in(intl), .ethertype_load_in(eld), .ethertype_value_in(ev), .in_data_in(d),
        .in_valid_in(v), .in_last_in(l), .in_ready_out(rdy), .meta_egress_port_in(eport),
        .meta_pause_in(pau), .meta_tc_in(tc), .meta_ingress_port_in(ipt), .meta_pppoe_in(ppp),
        .meta_ipv4_in(v4), .meta_l3_header_position_in(l3), .meta_port_map_in(pmap),
        .meta_duplicated_copy_in(dup), .meta_l2_known_in(kn), .meta_length_in(len),
        .meta_mac_error_in(err), .meta_dropped_in(drp), .meta_precedence_in(prec),
        .meta_flow_id_in(flow), .meta_error_code_in(ecode), .out_data_out(od),
        .out_valid_out(ov), .out_last_out(ol), .out_ready_in(ordy), .busy_out(busy));
    egress_sink_model sink (.clk_in(clk_in), .reset_n_in(rst_n), .data_in(od), .valid_in(ov),
        .last_in(ol), .stall_in(stall), .slow_in(slow), .ready_out(ordy));
    ////////////////////////////////////////////////////////////////////////
    // one compare for every kind of value; x matches only an x in the expected value
    task automatic check_word(input logic [31:0] g, input logic [31:0] x, input string m);
        num_checks++;
        if (g !== x) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, m, g, x);
        end
    endtask : check_word
    task automatic close_out;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    // reflected crc32, one byte; kept apart from the design's own code
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
        c = c ^ {24'h000000, b};
        for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ `TAG_CRC_POLY) : (c >> 1);
        return c;
    endfunction : crc_step
    ////////////////////////////////////////////////////////////////////////
    // send one frame, build the expected egress bytes, compare them all
    task automatic run_frame(input int n, input logic [7:0] seed);
        logic [7:0] f[$];
        logic [7:0] e[$];
        logic [7:0] t[8];
        logic [31:0] c;
        logic [13:0] lt;
        logic r;
        int k0;
        for (int k = 0; k < n; k++) f.push_back(seed + 8'(k) * 8'h1D);
        e = f;
        lt = len + 14'h0008; // length counts the tag too
        t[0] = intl[eport] ? {4'h0, err, drp, prec} : etype[15:8];
        t[1] = intl[eport] ? ((err | drp) ? ecode : flow) : etype[7:0];
        t[2] = {tc, ipt};
        t[3] = {ppp, v4, (l3 == 6'h00) ? 6'h00 : l3 + 6'h08};
        t[4] = pmap;
        t[5] = 8'h00; // reserved stays zero
        t[6] = {dup, kn, lt[13:8]};
        t[7] = lt[7:0];
        if (en[eport] && !pau && eport < 3'h7 && n > 12) begin
            for (int j = 7; j >= 0; j--) e.insert(12, t[j]); // tag right after source mac
        end
        c = `TAG_CRC_INIT;
        foreach (e[k]) c = crc_step(c, e[k]);
        c = ~c;
        for (int j = 0; j < 4; j++) e.push_back(c[8*j +: 8]); // fcs low byte first
        sink.got.delete();
        k0 = sink.frames;
        @(posedge clk_in); // a request changes only just after an edge
        for (int k = 0; k < n; k++) begin
            d <= f[k];
            v <= 1'b1;
            l <= (k == n - 1);
            do begin
                @(negedge clk_in);
                r = rdy;
                @(posedge clk_in);
            end while (r !== 1'b1);
        end
        v <= 1'b0;
        for (int k = 0; k < 400 && sink.frames == k0; k++) @(posedge clk_in);
        @(negedge clk_in);
        check_word(sink.got.size(), e.size(), "frame length");
        foreach (e[k]) check_word(sink.got[k], e[k], "egress byte");
        check_word({31'h0, busy}, 32'h0, "busy after frame");
    endtask : run_frame
    ////////////////////////////////////////////////////////////////////////
    // external format, one frame with wrapping length, one at the 13 byte edge
    task automatic t_external;
        {tc, ipt, ppp, v4, l3, pmap, dup, kn, len} = {8'hA6, 2'b11, 6'h0E, 8'h5A, 2'b10, 14'h3FFA};
        run_frame(20, 8'h11);
        {tc, ipt, ppp, v4, l3, pmap, dup, kn, len} = {8'h51, 2'b00, 6'h00, 8'hFF, 2'b01, 14'h0040};
        run_frame(13, 8'h22);
    endtask : t_external
    // internal format, every error, drop and precedence code, slow host
    task automatic t_internal;
        intl[eport] = 1'b1;
        slow = 1'b1;
        for (int i = 0; i < 4; i++) begin
            {drp, err} = 2'(i);
            prec = 2'(i);
            flow = 8'hC0 + 8'(i);
            ecode = 8'h30 + 8'(i);
            run_frame(16, 8'h40 + 8'(i));
        end
        intl[eport] = 1'b0;
        slow = 1'b0;
    endtask : t_internal
    // disabled port, pause frame, short frame, port out of range: no tag
    task automatic t_untagged;
        en[eport] = 1'b0;
        run_frame(30, 8'h60);
        en[eport] = 1'b1;
        pau = 1'b1;
        run_frame(20, 8'h70);
        pau = 1'b0;
        run_frame(12, 8'h80);
        eport = 3'h7;
        run_frame(20, 8'h90);
        eport = 3'h3;
    endtask : t_untagged
    // new ethertype applies to the following frames
    task automatic t_ethertype;
        @(posedge clk_in);
        eld <= 1'b1;
        ev <= 16'hA55A;
        @(posedge clk_in);
        eld <= 1'b0;
        etype = 16'hA55A;
        run_frame(14, 8'hA0);
    endtask : t_ethertype
    // host stalls: the buffer fills and the input is refused, then drains
    task automatic t_stall;
        stall = 1'b1;
        fork
            run_frame(40, 8'hB0);
            begin
                repeat (50) @(posedge clk_in);
                @(negedge clk_in);
                check_word({31'h0, rdy}, 32'h0, "input refused while full");
                check_word({31'h0, busy}, 32'h1, "busy during frame");
                stall = 1'b0;
            end
        join
    endtask : t_stall
    ////////////////////////////////////////////////////////////////////////
    // main sequence and watchdog
    initial begin
        repeat (4) @(posedge clk_in);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_in);
        t_external();
        t_internal();
        t_untagged();
        t_ethertype();
        t_stall();
        close_out();
    end
    initial begin
        #100000;
        n_errors++;
        close_out();
    end
endmodule : tb_egress_status_tag_inserter
